// *** hw/aopcc_pkg.sv ***
/*
  Constants for the offset, PLL and clamp configuration slice.
  Assumes a Wishbone slave with one 32-bit word per register.
*/
package aopcc_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [5:0] IDX_GREEN_OFFSET_HIGH = 6'h1a;
  localparam logic [5:0] IDX_GREEN_OFFSET_LOW = 6'h1b;
  localparam logic [5:0] IDX_BLUE_OFFSET_HIGH = 6'h1c;
  localparam logic [5:0] IDX_BLUE_OFFSET_LOW = 6'h1d;
  localparam logic [5:0] IDX_LINE_PERIOD_HIGH = 6'h1e;
  localparam logic [5:0] IDX_LINE_PERIOD_LOW = 6'h1f;
  localparam logic [5:0] IDX_SAMPLING_PHASE = 6'h20;
  localparam logic [5:0] IDX_COAST_LINES_BEFORE = 6'h21;
  localparam logic [5:0] IDX_COAST_LINES_AFTER = 6'h22;
  localparam logic [5:0] IDX_PLL_CONTROL_BITS = 6'h23;
  localparam logic [5:0] IDX_CLAMP_START_HIGH = 6'h24;
  localparam logic [5:0] IDX_CLAMP_START_LOW = 6'h25;
  localparam logic [5:0] IDX_CLAMP_WIDTH = 6'h26;
  localparam int NUM_REGS = 13;
  // ----------------------------------------
  // Reset values, in index order from 0x1a
  // ----------------------------------------
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h80, 8'h00, 8'h80, 8'h00, 8'h06, 8'h98, 8'h00,
    8'h04, 8'h04, 8'h00, 8'h00, 8'h02, 8'h10};
  // ----------------------------------------
  // Field positions of the PLL control register
  // ----------------------------------------
  localparam int BIT_LOCK_LEADING = 0;
  localparam int BIT_CLK_INV_EN = 1;
  localparam int BIT_EXT_COAST_SEL = 2;
  localparam int BIT_EXT_COAST_POL = 3;
  localparam int BIT_EXT_PIXEL_CLK = 4;
  // ----------------------------------------
  // Misc values
  // ----------------------------------------
  localparam logic [9:0] OFFSET_DAC_MID = 10'h200;
  localparam logic [7:0] DIGITAL_ZERO = 8'h80;
  localparam logic [13:0] LINE_PERIOD_RESET = 14'h0698;
endpackage : aopcc_pkg

// *** hw/aopcc_config.sv ***
/*
  Offset, PLL line period, sampling phase, coast and clamp configuration
  of a triple-channel video digitizer, with the timing that it steers.
  Assumes all inputs synchronous to clk_i, hsync and vsync active high,
  and a classic Wishbone master.
*/
// Register access over Wishbone was chosen for this implementation.
// How it works
// - Green high byte: DAC bits, or digital offset
// - Blue high byte: DAC bits, or digital offset
// - Low bytes hold offset bits 1:0 on top
// - Line period reaches PLL on low write only
// - Phase field picks one of 64 steps
// - Pre-coast lines before vsync, reset four
// - Post-coast lines after vsync, reset four
// - Bit 0 picks leading or trailing lock edge
// - Bit 1 lets clock invert pin act
// - Bit 2 picks external coast pin
// - Bit 3 makes external coast active low
// - Bit 4 picks external pixel clock
// - Clamp start pixel after hsync, reset two
// - Clamp width; zero keeps clamp off
// - Width never touches black-level window
// - Oversampling scales counts, divides pixel clock
`timescale 1ns/10ps
module aopcc_config (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Video side
  input wire logic auto_black_level_loop_i,
  input wire logic [1:0] oversample_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic ext_coast_i,
  input wire logic clock_invert_input_i,
  output logic [9:0] green_offset_dac_o,
  output logic [7:0] green_digital_offset_o,
  output logic [9:0] blue_offset_dac_o,
  output logic [7:0] blue_digital_offset_o,
  output logic [16:0] line_period_pixels_o,
  output logic [5:0] sampling_phase_o,
  output logic coast_o,
  output logic pll_ref_o,
  output logic clk_invert_o,
  output logic external_pixel_clock_in_o,
  output logic pixel_tick_o,
  output logic clamp_o,
  output logic black_level_start_o
);
  import aopcc_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] regs [NUM_REGS]; // Stored bytes, index 0 is 0x1a
  logic [13:0] lp_applied; // Line period held by the PLL
  wire [5:0] idx = adr_i[7:2]; // Word index
  wire req = cyc_i && stb_i && !ack_o; // New access this cycle
  wire hit = (idx >= IDX_GREEN_OFFSET_HIGH) && (idx <= IDX_CLAMP_WIDTH);
  wire [3:0] slot = 4'(idx - IDX_GREEN_OFFSET_HIGH); // Array slot
  wire wr = req && we_i && sel_i[0] && hit; // Byte lane 0 write
  wire [7:0] rd_byte = hit ? regs[slot] : 8'h00; // Unmapped reads 0

  // Named views of the stored bytes
  wire [7:0] g_hi = regs[0];
  wire [7:0] g_lo = regs[1];
  wire [7:0] b_hi = regs[2];
  wire [7:0] b_lo = regs[3];
  wire [7:0] pre_lines = regs[7];
  wire [7:0] post_lines = regs[8];
  wire [7:0] ctl = regs[9];
  wire [13:0] clamp_start = {regs[10][5:0], regs[11]};
  wire [7:0] clamp_width = regs[12];

  // One writable byte per slot, reset to its documented value
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          regs[gi] <= REG_RESET[gi];
        end else if (wr && slot == 4'(gi)) begin
          regs[gi] <= dat_i[7:0];
        end
      end
    end
  endgenerate

  // Bus answer: ack one cycle after the request, for any address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // PLL takes the period only when the low byte is written
  wire lp_load = wr && idx == IDX_LINE_PERIOD_LOW;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lp_applied <= LINE_PERIOD_RESET;
    end else if (lp_load) begin
      lp_applied <= {regs[4][5:0], dat_i[7:0]};
    end
  end

  // ----------------------------------------
  // Offsets
  // ----------------------------------------
  // With the loop off the DAC gets high byte and low bits 7:6;
  // with it on the DAC sits at mid scale and the high byte is a
  // digital offset, sent out as two's complement (0x80 means zero).
  wire [9:0] g_dac = auto_black_level_loop_i ? OFFSET_DAC_MID
                                             : {g_hi, g_lo[7:6]};
  wire [9:0] b_dac = auto_black_level_loop_i ? OFFSET_DAC_MID
                                             : {b_hi, b_lo[7:6]};
  wire [7:0] g_dig = auto_black_level_loop_i ? (g_hi ^ DIGITAL_ZERO)
                                             : 8'h00;
  wire [7:0] b_dig = auto_black_level_loop_i ? (b_hi ^ DIGITAL_ZERO)
                                             : 8'h00;

  // ----------------------------------------
  // Oversampling scale and pixel divider
  // ----------------------------------------
  logic [2:0] div_cnt; // Clocks within one output pixel
  wire [2:0] div_last = 3'((4'h1 << oversample_i) - 4'h1);
  wire div_wrap = div_cnt >= div_last; // Output pixel boundary
  wire [16:0] lp_scaled = 17'({3'h0, lp_applied} << oversample_i);
  wire [16:0] start_s = 17'({3'h0, clamp_start} << oversample_i);
  wire [16:0] width_s = 17'({9'h000, clamp_width} << oversample_i);


  // ----------------------------------------
  // Sync edges and coast
  // ----------------------------------------
  logic hs_d; // Hsync one cycle late
  logic vs_d; // Vsync one cycle late
  logic [10:0] line_cnt; // Lines since vsync start
  logic [10:0] frame_lines; // Lines in the previous frame
  logic [7:0] post_left; // Post-coast lines still to go
  wire hs_rise = hsync_i && !hs_d; // Leading edge
  wire hs_fall = !hsync_i && hs_d; // Trailing edge
  wire vs_rise = vsync_i && !vs_d;
  wire vs_fall = !vsync_i && vs_d;
  wire lock_edge = ctl[BIT_LOCK_LEADING] ? hs_rise : hs_fall;
  wire [11:0] pre_sum = {1'b0, line_cnt} + {4'h0, pre_lines};
  wire pre_coast = frame_lines != 11'h000
                   && pre_sum >= {1'b0, frame_lines};
  // The vsync falling cycle is covered too, before post_left loads
  wire int_coast = pre_coast || vsync_i || post_left != 8'h00
                   || (vs_fall && post_lines != 8'h00);
  wire ext_coast = ext_coast_i ^ ctl[BIT_EXT_COAST_POL];
  wire next_coast = ctl[BIT_EXT_COAST_SEL] ? ext_coast : int_coast;

  // Sync history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_d <= 1'b0;
      vs_d <= 1'b0;
    end else begin
      hs_d <= hsync_i;
      vs_d <= vsync_i;
    end
  end

  // Divides the pixel clock by the ratio; restarts on hsync trailing edge
  always_ff @(posedge clk_i) begin
    if (rst_i || div_wrap || hs_fall) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // Line counting per frame, for the lines before vsync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_cnt <= 11'h000;
      frame_lines <= 11'h000;
    end else if (vs_rise) begin
      frame_lines <= line_cnt;
      line_cnt <= 11'h000;
    end else if (hs_rise && line_cnt != 11'h7ff) begin
      line_cnt <= line_cnt + 11'h001;
    end
  end

  // Lines left to coast after vsync ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_left <= 8'h00;
    end else if (vs_fall) begin
      post_left <= post_lines;
    end else if (hs_rise && post_left != 8'h00) begin
      post_left <= post_left - 8'h01;
    end
  end

  // ----------------------------------------
  // Clamp and black-level window
  // ----------------------------------------
  logic [16:0] pix_cnt; // Clocks since hsync trailing edge
  logic pix_run; // Counting is under way
  wire [17:0] clamp_end = {1'b0, start_s} + {1'b0, width_s};
  wire in_clamp = pix_run && clamp_width != 8'h00
                  && pix_cnt >= start_s
                  && {1'b0, pix_cnt} < clamp_end;
  wire bl_hit = pix_run && pix_cnt == start_s;

  // Pixel counter restarts at each hsync trailing edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_cnt <= 17'h0_0000;
      pix_run <= 1'b0;
    end else if (hs_fall) begin
      pix_cnt <= 17'h0_0000;
      pix_run <= 1'b1;
    end else if (pix_run && pix_cnt != 17'h1_ffff) begin
      pix_cnt <= pix_cnt + 17'h0_0001;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      green_offset_dac_o <= OFFSET_DAC_MID;
      green_digital_offset_o <= 8'h00;
      blue_offset_dac_o <= OFFSET_DAC_MID;
      blue_digital_offset_o <= 8'h00;
      line_period_pixels_o <= 17'h0_0000;
      sampling_phase_o <= 6'h00;
      coast_o <= 1'b0;
      pll_ref_o <= 1'b0;
      clk_invert_o <= 1'b0;
      external_pixel_clock_in_o <= 1'b0;
      pixel_tick_o <= 1'b0;
      clamp_o <= 1'b0;
      black_level_start_o <= 1'b0;
    end else begin
      green_offset_dac_o <= g_dac;
      green_digital_offset_o <= g_dig;
      blue_offset_dac_o <= b_dac;
      blue_digital_offset_o <= b_dig;
      line_period_pixels_o <= lp_scaled;
      sampling_phase_o <= regs[6][5:0];
      coast_o <= next_coast;
      pll_ref_o <= lock_edge && !next_coast;
      clk_invert_o <= clock_invert_input_i && ctl[BIT_CLK_INV_EN];
      external_pixel_clock_in_o <= ctl[BIT_EXT_PIXEL_CLK];
      pixel_tick_o <= div_wrap;
      clamp_o <= in_clamp;
      black_level_start_o <= bl_hit;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  lp_high_only_a: assert property (
    wr && idx == IDX_LINE_PERIOD_HIGH |=> $stable(lp_applied))
    else $error("line period changed on high byte write");

  lp_low_load_a: assert property (
    lp_load |=> lp_applied == {regs[4][5:0], $past(dat_i[7:0])})
    else $error("line period not loaded on low byte write");

  clamp_zero_a: assert property (
    clamp_width == 8'h00 |=> !clamp_o)
    else $error("clamp connected with zero width");

  ext_coast_a: assert property (
    ctl[BIT_EXT_COAST_SEL] && $stable(ctl) |=>
      coast_o == $past(ext_coast_i ^ ctl[BIT_EXT_COAST_POL]))
    else $error("external coast not followed");

  ref_gate_a: assert property (
    pll_ref_o |-> !coast_o)
    else $error("reference edge passed during coast");

  ack_pulse_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

  clk_inv_gate_a: assert property (
    !ctl[BIT_CLK_INV_EN] |=> !clk_invert_o)
    else $error("clock invert pin acted while disabled");

  dac_mid_a: assert property (
    auto_black_level_loop_i |=> green_offset_dac_o == OFFSET_DAC_MID
      && blue_offset_dac_o == OFFSET_DAC_MID)
    else $error("offset DAC left mid scale with loop on");

  bl_start_a: assert property (
    black_level_start_o |-> $past(pix_cnt) == $past(start_s))
    else $error("black-level start at wrong pixel");

  ack_answer_a: assert property (
    req |=> ack_o)
    else $error("request not acknowledged in one cycle");

  unmapped_zero_a: assert property (
    req && !we_i && !hit |=> dat_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  width_write_a: assert property (
    wr && idx == IDX_CLAMP_WIDTH |=> clamp_width == $past(dat_i[7:0]))
    else $error("clamp width write did not land");

  green_dac_a: assert property (
    !auto_black_level_loop_i |=> green_offset_dac_o == $past({g_hi, g_lo[7:6]}))
    else $error("green offset DAC word wrong with loop off");

  blue_dac_a: assert property (
    !auto_black_level_loop_i |=> blue_offset_dac_o == $past({b_hi, b_lo[7:6]}))
    else $error("blue offset DAC word wrong with loop off");

  dig_off_a: assert property (
    !auto_black_level_loop_i |=> green_digital_offset_o == 8'h00
      && blue_digital_offset_o == 8'h00)
    else $error("digital offset nonzero with loop off");

  phase_follow_a: assert property (
    1'b1 |=> sampling_phase_o == $past(regs[6][5:0]))
    else $error("sampling phase does not follow its register");

  trail_edge_a: assert property (
    pll_ref_o && !$past(ctl[BIT_LOCK_LEADING]) |-> $past(hs_fall))
    else $error("reference not on trailing edge");

  lead_edge_a: assert property (
    pll_ref_o && $past(ctl[BIT_LOCK_LEADING]) |-> $past(hs_rise))
    else $error("reference not on leading edge");

  clk_inv_pass_a: assert property (
    ctl[BIT_CLK_INV_EN] && clock_invert_input_i |=> clk_invert_o)
    else $error("clock invert pin ignored while enabled");

  vs_coast_a: assert property (
    !ctl[BIT_EXT_COAST_SEL] && vsync_i |=> coast_o)
    else $error("no internal coast during vsync");

  pre_coast_a: assert property (
    !ctl[BIT_EXT_COAST_SEL] && pre_coast |=> coast_o)
    else $error("no coast in the lines before vsync");

  post_coast_a: assert property (
    !ctl[BIT_EXT_COAST_SEL] && post_left != 8'h00 |=> coast_o)
    else $error("no coast in the lines after vsync");

  xclk_follow_a: assert property (
    1'b1 |=> external_pixel_clock_in_o == $past(ctl[BIT_EXT_PIXEL_CLK]))
    else $error("pixel clock select does not follow its bit");

  tick_full_a: assert property (
    oversample_i == 2'h0 |=> pixel_tick_o)
    else $error("pixel tick missing at ratio one");

  bl_pulse_a: assert property (
    black_level_start_o |=> !black_level_start_o)
    else $error("black-level start longer than one cycle");

  clamp_window_a: assert property (
    clamp_o |-> $past(pix_cnt) >= $past(start_s))
    else $error("clamp connected before start pixel");
endmodule : aopcc_config

// *** tb/aopcc_config_tb_top.sv ***
/*
  Self-checking bench for the offset, PLL and clamp configuration slice.
  Assumes the design answers each Wishbone request with a one-cycle ack.
*/
`timescale 1ns/10ps
module aopcc_config_tb_top;
  import aopcc_pkg::*;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0; // Bus controls
  logic [7:0] adr_i = 8'h00; // Byte address
  logic [3:0] sel_i = 4'h0; // Byte enables
  logic [31:0] dat_i = 32'h0000_0000, dat_o; // Bus data
  logic ack_o, loop_i = 0, hs = 0, vs = 0, ec = 0, ci = 0; // Video side inputs
  logic [1:0] os = 2'h0; // Oversampling ratio code
  logic [9:0] g_dac, b_dac; // Offset converter words
  logic [7:0] g_dig, b_dig; // Digital offsets
  logic [16:0] lp; // Applied line period
  logic [5:0] ph; // Sampling phase
  logic coast, pref, cinv, xclk, tick, clamp, bls; // Timing outputs
  logic [31:0] q; // Read data taken at ack
  int num_errors = 0, n_tests = 0, ref_r, ref_f, clamp_n, bls_n; // Counters
  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;
  aopcc_config DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .auto_black_level_loop_i(loop_i), .oversample_i(os), .hsync_i(hs), .vsync_i(vs),
    .ext_coast_i(ec), .clock_invert_input_i(ci), .green_offset_dac_o(g_dac),
    .green_digital_offset_o(g_dig), .blue_offset_dac_o(b_dac), .blue_digital_offset_o(b_dig),
    .line_period_pixels_o(lp), .sampling_phase_o(ph), .coast_o(coast), .pll_ref_o(pref),
    .clk_invert_o(cinv), .external_pixel_clock_in_o(xclk), .pixel_tick_o(tick),
    .clamp_o(clamp), .black_level_start_o(bls));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares one value and reports a mismatch
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic Wishbone cycle on register index idx
  task wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {idx, 2'b00};
    sel_i <= 4'h1; dat_i <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc_i <= 0; stb_i <= 0;
    if (k >= 50) check(0, 1);
  endtask : wb
  // Waits for registered outputs to follow their causes
  task settle;
    repeat (3) @(posedge clk_i);
  endtask : settle
  // One line: hsync high for 10 clocks, then 60 clocks low, counting outputs
  task line;
    ref_r = 0; ref_f = 0; clamp_n = 0; bls_n = 0;
    @(posedge clk_i) hs <= 1;
    repeat (10) begin
      @(posedge clk_i);
      ref_r += (pref === 1'b1);
    end
    hs <= 0;
    repeat (60) begin
      @(posedge clk_i);
      ref_f += (pref === 1'b1); clamp_n += (clamp === 1'b1); bls_n += (bls === 1'b1);
    end
  endtask : line
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values of every register and an unmapped place
  task t_reset;
    for (int i = 0; i < NUM_REGS; i++) begin
      wb(0, IDX_GREEN_OFFSET_HIGH + 6'(i), 8'h00);
      check(q, {24'h00_0000, REG_RESET[i]});
    end
    wb(1, 6'h30, 8'h5a);
    wb(0, 6'h30, 8'h00);
    check(q, 32'h0000_0000);
    check(lp, 17'(LINE_PERIOD_RESET));
    check(tick, 1);
  endtask : t_reset
  // Offset words with the loop off, then digital offsets with it on
  task t_offset;
    wb(1, IDX_GREEN_OFFSET_HIGH, 8'ha5); wb(1, IDX_GREEN_OFFSET_LOW, 8'hc0);
    wb(1, IDX_BLUE_OFFSET_HIGH, 8'h3c); wb(1, IDX_BLUE_OFFSET_LOW, 8'h40);
    settle();
    check(g_dac, 10'h297);
    check(b_dac, 10'h0f1);
    check({g_dig, b_dig}, 16'h0000);
    loop_i <= 1;
    settle();
    check({g_dig, b_dig}, 16'h25bc);
    check({g_dac, b_dac}, 20'h8_0200);
    loop_i <= 0;
  endtask : t_offset
  // Line period applies on low write only, then scales with oversampling
  task t_period;
    int n; // Pixel ticks seen
    wb(1, IDX_LINE_PERIOD_HIGH, 8'h12);
    settle();
    check(lp, 17'h0_0698);
    wb(1, IDX_LINE_PERIOD_LOW, 8'h34);
    settle();
    check(lp, 17'h0_1234);
    os <= 2'h1;
    settle();
    check(lp, 17'h0_2468);
    n = 0;
    repeat (8) begin
      @(posedge clk_i);
      n += (tick === 1'b1);
    end
    check(n, 4);
    os <= 2'h0;
  endtask : t_period
  // Phase field, clock invert gate and external pixel clock select
  task t_misc;
    wb(1, IDX_SAMPLING_PHASE, 8'hff);
    ci <= 1;
    settle();
    check({ph, cinv, xclk}, 8'hfc);
    wb(1, IDX_PLL_CONTROL_BITS, 8'h12);
    settle();
    check({cinv, xclk}, 2'h3);
  endtask : t_misc
  // Lock edge selection, then external coast masking the reference
  task t_lock;
    wb(1, IDX_PLL_CONTROL_BITS, 8'h00);
    line();
    check(ref_r, 0);
    check(ref_f, 1);
    wb(1, IDX_PLL_CONTROL_BITS, 8'h01);
    line();
    check(ref_r, 1);
    check(ref_f, 0);
    wb(1, IDX_PLL_CONTROL_BITS, 8'h05);
    ec <= 1;
    settle();
    check(coast, 1);
    line();
    check(ref_r + ref_f, 0);
    wb(1, IDX_PLL_CONTROL_BITS, 8'h0d);
    settle();
    check(coast, 0);
    ec <= 0;
    settle();
    check(coast, 1);
    wb(1, IDX_PLL_CONTROL_BITS, 8'h00);
  endtask : t_lock
  // Clamp width counts, zero keeps it off, black-level start stays
  task t_clamp;
    line();
    check(clamp_n, 16);
    check(bls_n, 1);
    wb(1, IDX_CLAMP_WIDTH, 8'h00);
    line();
    check(clamp_n, 0);
    check(bls_n, 1);
  endtask : t_clamp
  // Internal coast: vsync, post lines after it, pre lines before the next
  task t_coast;
    wb(1, IDX_COAST_LINES_BEFORE, 8'h01);
    wb(1, IDX_COAST_LINES_AFTER, 8'h02);
    @(posedge clk_i) vs <= 1;
    settle();
    check(coast, 1);
    vs <= 0;
    line();
    check(coast, 1);
    check(ref_f, 0);
    line();
    check(coast, 0);
    check(ref_f, 1);
    line();
    check(ref_f, 1);
    line();
    check(coast, 1);
    check(ref_f, 0);
  endtask : t_coast
  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  task summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // Watchdog at 20000 cycles, well beyond the under 1000 cycles the run needs
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_reset(); t_offset(); t_period(); t_misc(); t_lock(); t_clamp();
    t_coast();
    summarize();
  end
endmodule : aopcc_config_tb_top
